// >>> verilog/decrement_divide_execution.v
`default_nettype none
`include "dec_div_defs.vh"

module decrement_divide_execution #(
  parameter WIDTH = `DD_DATA_W
) (
  input wire clk,
  input wire srst,
  input wire start,
  input wire op_div,
  input wire [`DD_SRC_W-1:0] src_sel,
  input wire [2:0] wreg_idx,
  input wire [WIDTH-1:0] direct_addr,
  input wire [WIDTH-1:0] ptr_value,
  input wire [WIDTH-1:0] acc_in,
  input wire [WIDTH-1:0] aux_in,
  input wire [WIDTH-1:0] wreg_data,
  input wire [WIDTH-1:0] mem_rdata,
  input wire loc_is_port,
  input wire [WIDTH-1:0] port_latch,
  input wire carry_in,
  input wire aux_carry_in,
  input wire overflow_in,
  output wire busy,
  output reg done_q,
  output reg acc_we_q,
  output reg [WIDTH-1:0] acc_wdata_q,
  output reg aux_we_q,
  output reg [WIDTH-1:0] aux_wdata_q,
  output reg wreg_we_q,
  output reg [2:0] wreg_widx_q,
  output reg [WIDTH-1:0] wreg_wdata_q,
  output reg mem_re_q,
  output reg mem_we_q,
  output reg [WIDTH-1:0] mem_addr_q,
  output reg [WIDTH-1:0] mem_wdata_q,
  output reg flags_we_q,
  output reg carry_out_q,
  output reg aux_carry_out_q,
  output reg overflow_out_q
);

  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_READ = 4'h2;
  localparam [3:0] S_CAPT = 4'h4;
  localparam [3:0] S_DIV = 4'h8;

  reg [3:0] state_q;
  reg port_q;
  wire take;
  wire div_zero;
  wire div_go;
  wire [WIDTH-1:0] quotient;
  wire [WIDTH-1:0] remainder;
  wire div_done;
  wire [WIDTH-1:0] mem_old;

  assign busy = (state_q != S_IDLE);
  assign take = start && (state_q == S_IDLE);
  assign div_zero = (aux_in == `DD_ZERO);
  assign div_go = take && (op_div == `DD_OP_DIV) && !div_zero;
  // port writes read back the latch, never the pins
  assign mem_old = port_q ? port_latch : mem_rdata;

  restoring_divider #(
    .WIDTH(WIDTH)
  ) u_div (
    .clk(clk),
    .srst(srst),
    .go(div_go),
    .dividend(acc_in),
    .divisor(aux_in),
    .quotient_q(quotient),
    .remainder_q(remainder),
    .done_q(div_done)
  );

  always @(posedge clk) begin
    if (srst) begin
      state_q <= S_IDLE;
      port_q <= 1'b0;
      done_q <= 1'b0;
      acc_we_q <= 1'b0;
      acc_wdata_q <= `DD_ZERO;
      aux_we_q <= 1'b0;
      aux_wdata_q <= `DD_ZERO;
      wreg_we_q <= 1'b0;
      wreg_widx_q <= 3'h0;
      wreg_wdata_q <= `DD_ZERO;
      mem_re_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= `DD_ZERO;
      mem_wdata_q <= `DD_ZERO;
      flags_we_q <= 1'b0;
      carry_out_q <= 1'b0;
      aux_carry_out_q <= 1'b0;
      overflow_out_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      acc_we_q <= 1'b0;
      aux_we_q <= 1'b0;
      wreg_we_q <= 1'b0;
      mem_re_q <= 1'b0;
      mem_we_q <= 1'b0;
      flags_we_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (take) begin
            // flag outputs mirror the inputs unless divide updates them
            carry_out_q <= carry_in;
            aux_carry_out_q <= aux_carry_in;
            overflow_out_q <= overflow_in;
            if (op_div == `DD_OP_DIV) begin
              if (div_zero) begin
                // nothing committed to acc or aux on zero divisor
                flags_we_q <= 1'b1;
                carry_out_q <= 1'b0;
                overflow_out_q <= 1'b1;
                done_q <= 1'b1;
              end else begin
                state_q <= S_DIV;
              end
            end else begin
              case (src_sel)
                `DD_SRC_ACC: begin
                  acc_we_q <= 1'b1;
                  acc_wdata_q <= acc_in - `DD_ONE;
                  done_q <= 1'b1;
                end
                `DD_SRC_WREG: begin
                  wreg_we_q <= 1'b1;
                  wreg_widx_q <= wreg_idx;
                  wreg_wdata_q <= wreg_data - `DD_ONE;
                  done_q <= 1'b1;
                end
                `DD_SRC_DIRECT: begin
                  mem_re_q <= 1'b1;
                  mem_addr_q <= direct_addr;
                  port_q <= loc_is_port;
                  state_q <= S_READ;
                end
                default: begin
                  // pointer-addressed bytes are never ports
                  mem_re_q <= 1'b1;
                  mem_addr_q <= ptr_value;
                  port_q <= 1'b0;
                  state_q <= S_READ;
                end
              endcase
            end
          end
        end
        S_READ: begin
          state_q <= S_CAPT;
        end
        S_CAPT: begin
          mem_we_q <= 1'b1;
          mem_wdata_q <= mem_old - `DD_ONE;
          done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        S_DIV: begin
          if (div_done) begin
            acc_we_q <= 1'b1;
            acc_wdata_q <= quotient;
            aux_we_q <= 1'b1;
            aux_wdata_q <= remainder;
            flags_we_q <= 1'b1;
            carry_out_q <= 1'b0;
            overflow_out_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // decrement_divide_execution

`default_nettype wire

// >>> shared/dec_div_defs.vh
`ifndef DEC_DIV_DEFS_VH
`define DEC_DIV_DEFS_VH

`define DD_DATA_W 8
`define DD_SRC_W 2
`define DD_SRC_ACC 2'h0
`define DD_SRC_WREG 2'h1
`define DD_SRC_DIRECT 2'h2
`define DD_SRC_INDIRECT 2'h3
`define DD_OP_DEC 1'h0
`define DD_OP_DIV 1'h1
`define DD_DIV_STEPS 4'h8
`define DD_ONE 8'h01
`define DD_ZERO 8'h00

`endif

// >>> verilog/restoring_divider.v
`default_nettype none
`include "dec_div_defs.vh"

// one quotient bit per clock, unsigned
module restoring_divider #(
  parameter WIDTH = `DD_DATA_W
) (
  input wire clk,
  input wire srst,
  input wire go,
  input wire [WIDTH-1:0] dividend,
  input wire [WIDTH-1:0] divisor,
  output reg [WIDTH-1:0] quotient_q,
  output reg [WIDTH-1:0] remainder_q,
  output reg done_q
);

  reg [WIDTH-1:0] quo_q;
  reg [WIDTH-1:0] rem_q;
  reg [WIDTH-1:0] dvs_q;
  reg [3:0] cnt_q;
  reg run_q;
  reg [WIDTH:0] trial;
  reg [WIDTH-1:0] rem_d;
  reg bit_d;

  always @* begin
    trial = {rem_q, quo_q[WIDTH-1]};
    if (trial >= {1'b0, dvs_q}) begin
      rem_d = trial[WIDTH-1:0] - dvs_q;
      bit_d = 1'b1;
    end else begin
      rem_d = trial[WIDTH-1:0];
      bit_d = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      quo_q <= {WIDTH{1'b0}};
      rem_q <= {WIDTH{1'b0}};
      dvs_q <= {WIDTH{1'b0}};
      cnt_q <= 4'h0;
      run_q <= 1'b0;
      quotient_q <= {WIDTH{1'b0}};
      remainder_q <= {WIDTH{1'b0}};
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (go) begin
        quo_q <= dividend;
        rem_q <= {WIDTH{1'b0}};
        dvs_q <= divisor;
        cnt_q <= `DD_DIV_STEPS;
        run_q <= 1'b1;
      end else if (run_q) begin
        quo_q <= {quo_q[WIDTH-2:0], bit_d};
        rem_q <= rem_d;
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          run_q <= 1'b0;
          done_q <= 1'b1;
          quotient_q <= {quo_q[WIDTH-2:0], bit_d};
          remainder_q <= rem_d;
        end
      end
    end
  end

endmodule // restoring_divider

`default_nettype wire

// >>> bench/dd_properties.sv
`default_nettype none
module dd_checker #(parameter WIDTH = 8) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic op_div,
  input wire logic [1:0] src_sel,
  input wire logic [WIDTH-1:0] acc_in,
  input wire logic [WIDTH-1:0] aux_in,
  input wire logic carry_in,
  input wire logic busy,
  input wire logic done_q,
  input wire logic acc_we_q,
  input wire logic [WIDTH-1:0] acc_wdata_q,
  input wire logic aux_we_q,
  input wire logic mem_re_q,
  input wire logic mem_we_q,
  input wire logic flags_we_q,
  input wire logic carry_out_q,
  input wire logic overflow_out_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire take = start && !busy;
  wire dec_a = take && !op_div && src_sel == 2'h0;
  wire div_n = take && op_div && aux_in != 8'h00;
  wire div_z = take && op_div && aux_in == 8'h00;
  a_dec_wrap: assert property (dec_a |=> acc_we_q &&
    acc_wdata_q == $past(acc_in) - 8'h01) else $error("wrap");
  a_dec_flags: assert property (dec_a |=> !flags_we_q &&
    carry_out_q == $past(carry_in)) else $error("flags");
  a_mem_rmw: assert property (take && !op_div && src_sel[1] |=>
    mem_re_q ##2 mem_we_q && done_q) else $error("rmw");
  a_div_quot: assert property (div_n |-> ##10 acc_we_q &&
    acc_wdata_q == $past(acc_in, 10) / $past(aux_in, 10)) else $error("quot");
  a_div_flags: assert property (div_n |-> ##10 flags_we_q &&
    !carry_out_q && !overflow_out_q) else $error("div");
  a_div_zero: assert property (div_z |=> flags_we_q &&
    overflow_out_q && !acc_we_q) else $error("zero");
  a_carry_clear: assert property (flags_we_q |-> !carry_out_q)
    else $error("carry");
  a_commit_pair: assert property (acc_we_q && aux_we_q |-> flags_we_q)
    else $error("pair");
endmodule // dd_checker
bind decrement_divide_execution dd_checker #(.WIDTH(WIDTH)) u_dd_checker (.*);
`default_nettype wire

// >>> bench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, srst = 1'h1, start = 1'h0, op_div = 1'h0, loc_is_port = 1'h0;
  logic [1:0] src_sel = 2'h0;
  logic [7:0] acc_in = 8'h00, aux_in = 8'h00;
  logic [2:0] flags_in = 3'h0;
  logic busy_seen;
  wire busy, done_q, acc_we_q, aux_we_q, wreg_we_q, mem_re_q, mem_we_q, flags_we_q;
  wire carry_out_q, aux_carry_out_q, overflow_out_q;
  wire [2:0] wreg_widx_q;
  wire [7:0] acc_wdata_q, aux_wdata_q, wreg_wdata_q, mem_addr_q, mem_wdata_q;
  int mismatches = 0, samples_checked = 0;
  decrement_divide_execution u_decrement_divide_execution (.carry_in(flags_in[2]),
    .aux_carry_in(flags_in[1]), .overflow_in(flags_in[0]), .wreg_data(acc_in),
    .mem_rdata(acc_in), .wreg_idx(acc_in[2:0]), .port_latch(aux_in),
    .direct_addr(aux_in), .ptr_value(~aux_in), .*);
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input logic o, p, input logic [1:0] s, input logic [7:0] a, b,
    input logic [2:0] f);
    int n;
    @(posedge clk);
    start <= 1'h1;
    op_div <= o;
    src_sel <= s;
    loc_is_port <= p;
    acc_in <= a;
    aux_in <= b;
    flags_in <= f;
    @(posedge clk);
    start <= 1'h0;
    n = 0;
    // look half a period after each edge, never in the launching step
    do begin
      @(negedge clk);
      n++;
      if (n == 1) busy_seen = busy;
    end while (done_q !== 1'h1 && n < 16);
    if (done_q !== 1'h1) mismatches++;
  endtask
  task automatic t_dec_regs;
    run(1'h0, 1'h0, 2'h0, 8'h00, 8'h00, 3'h5);
    chk({acc_we_q, acc_wdata_q[6:0]}, 8'hff);
    chk(acc_wdata_q, 8'hff);
    chk({flags_we_q, carry_out_q, aux_carry_out_q, overflow_out_q}, 8'h05);
    chk(busy_seen, 8'h00);
    run(1'h0, 1'h0, 2'h1, 8'h83, 8'h00, 3'h2);
    chk({wreg_we_q, wreg_widx_q}, 8'h0b);
    chk(wreg_wdata_q, 8'h82);
    chk({flags_we_q, carry_out_q, aux_carry_out_q, overflow_out_q}, 8'h02);
    $display("dec regs test done");
  endtask
  task automatic t_dec_mem;
    run(1'h0, 1'h0, 2'h2, 8'h40, 8'h11, 3'h0);
    chk(mem_addr_q, 8'h11);
    chk(mem_wdata_q, 8'h3f);
    chk(busy_seen, 8'h01);
    run(1'h0, 1'h1, 2'h2, 8'h55, 8'h11, 3'h7);
    chk(mem_wdata_q, 8'h10);
    chk({flags_we_q, carry_out_q, aux_carry_out_q, overflow_out_q}, 8'h07);
    run(1'h0, 1'h1, 2'h3, 8'h01, 8'h20, 3'h1);
    chk(mem_addr_q, 8'hdf);
    chk(mem_wdata_q, 8'h00);
    $display("dec mem test done");
  endtask
  task automatic t_div;
    run(1'h1, 1'h0, 2'h0, 8'hfb, 8'h12, 3'h7);
    chk(acc_wdata_q, 8'h0d);
    chk(aux_wdata_q, 8'h11);
    chk({flags_we_q, carry_out_q, overflow_out_q}, 8'h04);
    chk(busy_seen, 8'h01);
    run(1'h1, 1'h0, 2'h0, 8'h05, 8'h80, 3'h0);
    chk({acc_wdata_q[3:0], aux_wdata_q[3:0]}, 8'h05);
    run(1'h1, 1'h0, 2'h0, 8'h33, 8'h00, 3'h6);
    chk({flags_we_q, carry_out_q, overflow_out_q, acc_we_q, aux_we_q}, 8'h14);
    chk(busy_seen, 8'h00);
    $display("div test done");
  endtask
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    t_dec_regs();
    t_dec_mem();
    t_div();
    end_of_test();
  end
  initial begin
    #5000;
    mismatches++;
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
